// ### inc/ifms_defs.vh
/*
  Constants shared by the two-wire memory slave and its write FIFO.
  Assumes it is included by bare name from design files compiled with inc/ on the search path.
*/
`ifndef IFMS_DEFS_VH
`define IFMS_DEFS_VH

// Array geometry: 2048 locations of eight bits.
`define IFMS_ADDR_W 11
`define IFMS_DATA_W 8
`define IFMS_MEM_DEPTH 2048

// Reset value of the internal address latch.
`define IFMS_ADDR_RST 11'h000

// Fields of the first byte after START.
`define IFMS_DEV_TYPE_HI 7
`define IFMS_DEV_TYPE_LO 4
`define IFMS_PAGE_HI 3
`define IFMS_PAGE_LO 1
`define IFMS_RW_BIT 0

// Bits per byte on the wire, as a bit counter value.
`define IFMS_BYTE_BITS 4'h8

// Write buffer depth in words.
`define IFMS_FIFO_DEPTH 32

`endif

// ### src/ifms_fifo.v
/*
  Synchronous FIFO with valid/ready on both sides, used as the write buffer.
  Assumes one clock and an asynchronous active-low reset shared with the slave.
*/
`timescale 1ns/1ps
module ifms_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_i,               // System clock.
  input wire rstn_i,              // Asynchronous reset, active low.
  input wire in_valid_i,          // Producer offers a word.
  output wire in_ready_o,         // FIFO can take a word.
  input wire [WIDTH-1:0] in_data_i, // Word offered.
  output wire out_valid_o,        // A word is waiting.
  input wire out_ready_i,         // Consumer takes the word.
  output wire [WIDTH-1:0] out_data_o // Oldest word.
);

  reg [WIDTH-1:0] store [0:DEPTH-1]; // Word storage.
  reg [AW-1:0] wr_ptr;                // Next slot to fill.
  reg [AW-1:0] rd_ptr;                // Oldest slot.
  reg [AW:0] count;                   // Words held, one bit wider than the pointers.

  wire do_push; // A word enters this cycle.
  wire do_pop;  // A word leaves this cycle.

  // Full and empty come straight from the count, so they never lie.
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = store[rd_ptr];
  assign do_push = in_valid_i & in_ready_o;
  assign do_pop = out_valid_o & out_ready_i;

  // Storage has no reset; only the pointers and count define what is valid.
  always @(posedge clk_i) begin
    if (do_push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap naturally because DEPTH is a power of two.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ### src/ifms_slave.v
/*
  Two-wire serial slave in front of a 2048 x 8 nonvolatile byte memory.
  Assumes an external master drives the serial clock and START/STOP framing, that the
  data line has an outside pull-up, and that MCLK_I runs at 40 MHz, far above the serial clock.
*/
// What this block does
// - Holds 2048 byte-wide locations behind the serial port.
// - Commits each received byte right after receipt.
// - Never busy; new transaction accepted at once.
// - Samples on clock rise, drives on fall.
// - Write-protect high blocks all writes.
// - Floating write-protect reads low, writes enabled; no pull-down here, only reset loads the WP stages low.
// - Data line driven low or released only.
// - Works from 100 kHz up to 1 MHz.
// - First byte: type, page, read/write bit.
// - Write loads 11-bit address; read loads page.
// - Address increments before acknowledge, wraps to zero.
// - Reads continue on acknowledge, end on none.
`timescale 1ns/1ps
`include "ifms_defs.vh"
module ifms_slave #(
  parameter [3:0] DEV_TYPE = 4'h5,  // Device-type field; value is arbitrary.
  parameter FIFO_DEPTH = `IFMS_FIFO_DEPTH,
  parameter FIFO_AW = 5
) (
  input wire MCLK_I,    // System clock, 40 MHz.
  input wire RSTN_I,    // Asynchronous reset, active low.
  input wire SCL_I,     // Serial clock from the master.
  input wire SDA_I,     // Data line level as seen on the wire.
  output reg SDA_O,     // Data line output value, always low.
  output reg SDA_OE_O,  // High while pulling the data line low.
  input wire WP_I       // Write protect, high blocks writes.
);

  localparam AW = `IFMS_ADDR_W;
  localparam DW = `IFMS_DATA_W;

  // Protocol states.
  localparam [2:0] ST_IDLE = 3'h0;  // Not addressed; wait for START.
  localparam [2:0] ST_DEV = 3'h1;   // Receiving the first byte.
  localparam [2:0] ST_WADR = 3'h2;  // Receiving the word address.
  localparam [2:0] ST_WDAT = 3'h3;  // Receiving write data.
  localparam [2:0] ST_ACK = 3'h4;   // Driving our acknowledge bit.
  localparam [2:0] ST_RDAT = 3'h5;  // Sending a read byte.
  localparam [2:0] ST_RACK = 3'h6;  // Waiting for the master's acknowledge.

  // Address step with natural wrap from the top location to zero.
  function [AW-1:0] addr_step;
    input [AW-1:0] a;
    begin
      addr_step = a + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  reg scl_m;  // First synchroniser stage, clock.
  reg sda_m;  // First synchroniser stage, data.
  reg wp_m;   // First synchroniser stage, write protect.
  reg scl_s;  // Synchronised clock.
  reg sda_s;  // Synchronised data.
  reg wp_s;   // Synchronised write protect.
  reg scl_d;  // Synchronised clock one cycle older.
  reg sda_d;  // Synchronised data one cycle older.

  reg [2:0] state;        // Protocol state.
  reg [2:0] after_ack;    // State to enter when our acknowledge ends.
  reg [3:0] bit_cnt;      // Bits moved in the current byte.
  reg [DW-1:0] shift;     // Receive shift register.
  reg [AW-1:0] addr;      // Internal address latch.
  reg master_ack;         // Master pulled the line low in its acknowledge slot.
  reg fetch;              // One-cycle request to read the array at addr.
  reg push;               // One-cycle request to buffer a write.
  reg [AW+DW-1:0] push_word; // Address and data of the buffered write.

  reg [DW-1:0] mem [0:`IFMS_MEM_DEPTH-1]; // Storage array.
  reg [DW-1:0] rd_byte;   // Byte being sent on a read.

  wire scl_rise;  // Serial clock rising edge.
  wire scl_fall;  // Serial clock falling edge.
  wire start_cond; // Data falls while clock high.
  wire stop_cond;  // Data rises while clock high.
  wire fifo_in_ready;  // Buffer has room.
  wire fifo_out_valid; // Buffer holds a write.
  wire [AW+DW-1:0] fifo_out_data; // Oldest buffered write.
  wire drain;          // A buffered write goes to the array now.

  // Pins come from the master's domain, so each passes two flops before any logic
  // reads it. The write-protect stages reset low; the block has no internal pull-down,
  // so a floating pin is not held low after reset. Sampling at 40 MHz leaves many
  // samples per clock phase even at the 1 MHz rate.
  always @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      scl_m <= 1'b1;
      sda_m <= 1'b1;
      wp_m <= 1'b0;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      wp_s <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= SCL_I;
      sda_m <= SDA_I;
      wp_m <= WP_I;
      scl_s <= scl_m;
      sda_s <= sda_m;
      wp_s <= wp_m;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Edge and framing detection looks only at the second stage and its delayed copy.
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // Protocol engine. START or STOP aborts whatever is in progress and releases the
  // line, so the device is ready for a new transaction at any time with no busy state.
  always @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      addr <= `IFMS_ADDR_RST;
      master_ack <= 1'b0;
      fetch <= 1'b0;
      push <= 1'b0;
      push_word <= {(AW+DW){1'b0}};
      SDA_O <= 1'b0;
      SDA_OE_O <= 1'b0;
    end else begin
      fetch <= 1'b0;
      push <= 1'b0;
      SDA_O <= 1'b0;
      if (start_cond) begin
        state <= ST_DEV;
        bit_cnt <= 4'h0;
        SDA_OE_O <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        SDA_OE_O <= 1'b0;
      end else begin
        case (state)
          ST_DEV, ST_WADR, ST_WDAT: begin
            if (scl_rise && bit_cnt != `IFMS_BYTE_BITS) begin
              shift <= {shift[DW-2:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `IFMS_BYTE_BITS) begin
              bit_cnt <= 4'h0;
              if (state == ST_DEV) begin
                if (shift[`IFMS_DEV_TYPE_HI:`IFMS_DEV_TYPE_LO] == DEV_TYPE) begin
                  // Page select is latched for both directions; a read keeps the low byte.
                  addr[AW-1:DW] <= shift[`IFMS_PAGE_HI:`IFMS_PAGE_LO];
                  fetch <= shift[`IFMS_RW_BIT];
                  after_ack <= shift[`IFMS_RW_BIT] ? ST_RDAT : ST_WADR;
                  SDA_OE_O <= 1'b1;
                  state <= ST_ACK;
                end else begin
                  // Another device is addressed; stay off the line.
                  state <= ST_IDLE;
                end
              end else if (state == ST_WADR) begin
                addr[DW-1:0] <= shift;
                after_ack <= ST_WDAT;
                SDA_OE_O <= 1'b1;
                state <= ST_ACK;
              end else if (!fifo_in_ready) begin
                // Buffer full: refuse the byte so the master sees back-pressure.
                state <= ST_IDLE;
              end else begin
                // Protected bytes are acknowledged but never reach the array.
                push <= ~wp_s;
                push_word <= {addr, shift};
                addr <= addr_step(addr);
                after_ack <= ST_WDAT;
                SDA_OE_O <= 1'b1;
                state <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            // Our acknowledge ends on the next falling edge.
            if (scl_fall) begin
              state <= after_ack;
              if (after_ack == ST_RDAT) begin
                SDA_OE_O <= ~rd_byte[DW-1];
                bit_cnt <= 4'h1;
              end else begin
                SDA_OE_O <= 1'b0;
              end
            end
          end
          ST_RDAT: begin
            if (scl_fall) begin
              if (bit_cnt == `IFMS_BYTE_BITS) begin
                // Release for the master's slot; address steps before that slot.
                SDA_OE_O <= 1'b0;
                addr <= addr_step(addr);
                bit_cnt <= 4'h0;
                state <= ST_RACK;
              end else begin
                SDA_OE_O <= ~rd_byte[3'h7 - bit_cnt[2:0]];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_s;
              fetch <= ~sda_s;
            end else if (scl_fall) begin
              if (master_ack) begin
                SDA_OE_O <= ~rd_byte[DW-1];
                bit_cnt <= 4'h1;
                state <= ST_RDAT;
              end else begin
                // No acknowledge ends the read and keeps the line free for STOP.
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Array port. A read fetch wins the single port and stalls the buffer drain for
  // that cycle; the buffer empties within a few system clocks of each byte, long
  // before the next serial byte can arrive, so reads always see earlier writes.
  assign drain = fifo_out_valid & ~fetch;

  always @(posedge MCLK_I) begin
    if (fetch) begin
      rd_byte <= mem[addr];
    end else if (drain) begin
      mem[fifo_out_data[AW+DW-1:DW]] <= fifo_out_data[DW-1:0];
    end
  end

  // Write buffer between the byte receiver and the array.
  ifms_fifo #(
    .WIDTH(AW + DW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_wbuf (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(~fetch),
    .out_data_o(fifo_out_data)
  );

endmodule

// ### verification/ifms_slave_monitor.sv
/*
  Pin-level checker for the two-wire memory slave.
  Assumes it is bound to ifms_slave and sees only that module's ports.
*/
`timescale 1ns/1ps
module ifms_slave_monitor #(
  parameter [3:0] DEV_TYPE = 4'h5  // Device-type field that earns an acknowledge.
) (
  input wire MCLK_I,    // System clock.
  input wire RSTN_I,    // Reset, active low.
  input wire SCL_I,     // Serial clock.
  input wire SDA_I,     // Resolved data wire.
  input wire SDA_O,     // Data output value.
  input wire SDA_OE_O,  // Data pull-down enable.
  input wire WP_I       // Write protect.
);
  reg scl_q;           // Serial clock one sample back.
  reg sda_q;           // Data wire one sample back.
  reg in_frame;        // High between START and STOP.
  reg [3:0] rise_cnt;  // Clock rises since START, saturating.
  reg [7:0] hdr;       // First byte after START.
  wire start = scl_q && SCL_I && sda_q && !SDA_I;  // Data falls while clock high.
  wire stop = scl_q && SCL_I && !sda_q && SDA_I;   // Data rises while clock high.
  wire rise = !scl_q && SCL_I;                     // Clock rising sample.

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  // Framing tracker; it lets the header acknowledge be judged independently of the design.
  always @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      rise_cnt <= 4'h0;
      hdr <= 8'h00;
    end else begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
      if (start) begin
        in_frame <= 1'b1;
        rise_cnt <= 4'h0;
      end else if (stop) begin
        in_frame <= 1'b0;
      end else if (rise && rise_cnt != 4'hF) begin
        rise_cnt <= rise_cnt + 4'h1;
        if (rise_cnt < 4'h8) begin
          hdr <= {hdr[6:0], SDA_I};
        end
      end
    end
  end

  AST_SDA_LOW_ONLY: assert property (!SDA_O) else $error("data output value not low");
  AST_OE_RISE_SCL_LOW: assert property ($rose(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2))
    else $error("data driven low outside clock low phase");
  AST_OE_STABLE_SCL_HIGH: assert property (SCL_I && $past(SCL_I, 3) |-> $stable(SDA_OE_O))
    else $error("data enable moved while clock high");
  AST_START_RELEASE: assert property (start |-> ##[1:5] !SDA_OE_O) else $error("start not honoured");
  AST_OE_HOLDS_BIT: assert property ($rose(SDA_OE_O) |-> SDA_OE_O [*6])
    else $error("data low shorter than a bit time");
  AST_IDLE_RELEASED: assert property (!in_frame |-> !SDA_OE_O) else $error("data driven outside frame");
  AST_HDR_SILENT: assert property (in_frame && rise_cnt < 4'h8 |-> !SDA_OE_O)
    else $error("data driven during header byte");
  AST_HDR_ACK: assert property (in_frame && rise && rise_cnt == 4'h8 |->
    SDA_OE_O == (hdr[7:4] == DEV_TYPE))
    else $error("header acknowledge wrong");

  COV_START: cover property (start);
  COV_HDR_ACK: cover property (rise && rise_cnt == 4'h8 && SDA_OE_O);
  COV_DATA_DRIVE: cover property ($rose(SDA_OE_O) && in_frame && rise_cnt > 4'h8);
endmodule

bind ifms_slave ifms_slave_monitor #(.DEV_TYPE(DEV_TYPE)) ifms_slave_monitor_inst (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .WP_I(WP_I));

// ### verification/ifms_master_model.sv
/*
  Behavioural two-wire bus master: 200 ns clock period, four system clocks per phase.
  Assumes the bench resolves the data wire with a pull-up and feeds it back on sda_i.
*/
`timescale 1ns/1ps
module ifms_master_model (
  input wire clk_i,      // System clock used to pace the bus.
  input wire sda_i,      // Resolved data wire.
  output reg scl_o,      // Serial clock; stands high outside frames.
  output reg sda_low_o   // High while the master pulls data low.
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Data changes with the clock low, except START and STOP, which change it with the clock high; the wire is read mid-high.
  task send_start;
    @(posedge clk_i) sda_low_o <= 1'b0;
    @(posedge clk_i) scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_low_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task send_stop;
    @(posedge clk_i) sda_low_o <= 1'b1;
    @(posedge clk_i) scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_low_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // One bit slot; r is the wire seen while the clock is high.
  task bit_slot(input b, output r);
    @(posedge clk_i) sda_low_o <= !b;
    @(posedge clk_i) scl_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    r = sda_i;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Eight bits out, most significant first, then the acknowledge slot.
  task wr_byte(input [7:0] d, output ack);
    integer i;
    reg r;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_slot(d[i], r);
    end
    bit_slot(1'b1, r);
    ack = !r;
  endtask

  // Eight bits in; the last byte is left unacknowledged.
  task rd_byte(input last, output [7:0] d);
    integer i;
    reg r;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_slot(1'b1, r);
      d[i] = r;
    end
    bit_slot(last, r);
  endtask
endmodule

// ### verification/testbench.sv
/*
  Self-checking bench for the two-wire memory slave.
  Assumes ifms_slave, its FIFO and the master model are compiled before this file.
*/
`timescale 1ns/1ps
module testbench;
  localparam [3:0] DEV = 4'h5;  // Device-type field; value is arbitrary.
  reg mclk;                     // System clock.
  reg rstn;                     // Reset, active low.
  reg wp;                       // Write protect; low models the pull-down.
  wire scl;                     // Serial clock from the master.
  wire sda;                     // Resolved data wire.
  wire sda_o;                   // Slave data value.
  wire sda_oe;                  // Slave pull-down enable.
  wire m_low;                   // Master pull-down.
  reg k;                        // Last acknowledge seen.
  reg [7:0] rd;                 // Last byte read.
  integer error_cnt = 0;        // Mismatches.
  integer checks_done = 0;      // Comparisons made.
  integer cyc = 0;              // Cycles run.

  assign sda = !(m_low | sda_oe);  // Wired-AND with pull-up.

  ifms_slave #(.DEV_TYPE(DEV)) ifms_slave_inst (.MCLK_I(mclk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .WP_I(wp));
  ifms_master_model ifms_master_model_inst (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task chk(input [7:0] seen, input [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // START, header and word address; both bytes must be acknowledged.
  task open_w(input [10:0] a);
    ifms_master_model_inst.send_start;
    ifms_master_model_inst.wr_byte({DEV, a[10:8], 1'b0}, k);
    chk({7'h00, k}, 8'h01);
    ifms_master_model_inst.wr_byte(a[7:0], k);
    chk({7'h00, k}, 8'h01);
  endtask

  task put(input [7:0] d);
    ifms_master_model_inst.wr_byte(d, k);
    chk({7'h00, k}, 8'h01);
  endtask

  task open_r(input [2:0] pg);
    ifms_master_model_inst.send_start;
    ifms_master_model_inst.wr_byte({DEV, pg, 1'b1}, k);
    chk({7'h00, k}, 8'h01);
  endtask

  // Burst across the top of the array; the read starts from the held low address.
  task t_wrap;
    open_w(11'h7FE);
    put(8'hA1);
    put(8'hB2);
    put(8'hC3);
    ifms_master_model_inst.send_stop;
    open_w(11'h7FE);
    ifms_master_model_inst.send_stop;
    open_r(3'h7);
    ifms_master_model_inst.rd_byte(1'b0, rd);
    chk(rd, 8'hA1);
    ifms_master_model_inst.rd_byte(1'b0, rd);
    chk(rd, 8'hB2);
    ifms_master_model_inst.rd_byte(1'b1, rd);
    chk(rd, 8'hC3);
    // The data output value must never be anything but low; look off the clock edge.
    @(negedge mclk);
    chk({7'h00, sda_o}, 8'h00);
    ifms_master_model_inst.send_stop;
  endtask

  // A protected write is acknowledged but leaves the array unchanged.
  task t_wp;
    open_w(11'h123);
    put(8'h5A);
    ifms_master_model_inst.send_stop;
    @(posedge mclk) wp <= 1'b1;
    open_w(11'h123);
    put(8'hA5);
    ifms_master_model_inst.send_stop;
    @(posedge mclk) wp <= 1'b0;
    open_w(11'h123);
    ifms_master_model_inst.send_stop;
    open_r(3'h1);
    ifms_master_model_inst.rd_byte(1'b1, rd);
    chk(rd, 8'h5A);
    ifms_master_model_inst.send_stop;
  endtask

  // Wrong device type is ignored; repeated STARTs are then served at once. The write
  // leaves the latch one past the byte, so a second write header moves it back first.
  task t_type;
    ifms_master_model_inst.send_start;
    ifms_master_model_inst.wr_byte({DEV ^ 4'h3, 3'h2, 1'b0}, k);
    chk({7'h00, k}, 8'h00);
    open_w(11'h200);
    put(8'h3C);
    open_w(11'h200);
    open_r(3'h2);
    ifms_master_model_inst.rd_byte(1'b1, rd);
    chk(rd, 8'h3C);
    ifms_master_model_inst.send_stop;
  endtask

  // Hang guard: far above the few thousand cycles the scenarios need.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  end

  initial begin
    rstn = 1'b0;
    wp = 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_wrap;
    t_wp;
    t_type;
    conclude;
  end
endmodule
